// file: pkg/system_mode_clock_pkg.sv
/*
  Constants for the system mode and clock configuration block: field positions,
  values after reset, port mode codes and cycle counts at a 100 MHz core clock.
  Assumes no other package; every user names items as system_mode_clock_pkg::name.
*/
`default_nettype none
package system_mode_clock_pkg;

  // Core clock
  localparam int CLK_PERIOD_NS = 10;

  // Start-up delays selected by the start-up fuse, least times so rounded up
  localparam int STARTUP0_NS  = 1000;
  localparam int STARTUP1_NS  = 2000;
  localparam int STARTUP2_NS  = 4000;
  localparam int STARTUP3_NS  = 8000;
  localparam int STARTUP0_CYC = (STARTUP0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STARTUP1_CYC = (STARTUP1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STARTUP2_CYC = (STARTUP2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STARTUP3_CYC = (STARTUP3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Clock setup register fields
  localparam int CLK_DIV_LSB   = 1;
  localparam int TMR_SCALE_LSB = 4;

  // Auxiliary register fields
  localparam int AUX_STROBE_OFF_BIT = 0;
  localparam int AUX_XSPACE_BIT     = 1;
  localparam int AUX_WAIT_LSB       = 2;

  // Memory control register fields
  localparam int MEM_DFLASH_BIT   = 3;
  localparam int MEM_SELFPROG_BIT = 7;

  // Values after reset
  localparam logic [7:0] CLK_RESET_COMPAT = 8'h52;
  localparam logic [7:0] CLK_RESET_FAST   = 8'h00;
  localparam logic [7:0] AUX_RESET        = 8'h00;
  localparam logic [7:0] MEM_RESET        = 8'h00;
  localparam logic [7:0] PORT_MODE_REGISTER_RESET_QUASI = 8'h00;
  localparam logic [7:0] PORT_MODE_REGISTER_RESET_INPUT = 8'hAA;

  // Port modes, one pair per port
  localparam logic [1:0] PM_QUASI      = 2'h0;
  localparam logic [1:0] PM_PUSH_PULL  = 2'h1;
  localparam logic [1:0] PM_INPUT      = 2'h2;
  localparam logic [1:0] PM_OPEN_DRAIN = 2'h3;

  // Register write selects
  localparam logic [1:0] SEL_CLOCK = 2'h0;
  localparam logic [1:0] SEL_AUX   = 2'h1;
  localparam logic [1:0] SEL_MEM   = 2'h2;
  localparam logic [1:0] SEL_PORT  = 2'h3;

  // Execution timing in system clocks
  localparam int COMPAT_FETCH_TICKS = 3;
  localparam int COMPAT_STATE_TICKS = 6;

  // Least external reset pulse in system clocks
  localparam int RST_MIN_COMPAT = 12;
  localparam int RST_MIN_FAST   = 2;

endpackage
`default_nettype wire

// file: core/rate_divider.sv
/*
  Programmable divider: counts step pulses and gives one tick per limit+1 steps.
  Assumes step and limit come from logic on core_clk; the tick is registered.
*/
`default_nettype none
module rate_divider #(
  parameter int WIDTH = 4
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_b,
  input  wire logic             clkEn,
  // Control
  input  wire logic             clear,
  input  wire logic             stepIn,
  input  wire logic [WIDTH-1:0] limit,
  // Result
  output var  logic             tick
);

  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;
  logic             next_tick;

  always_comb begin
    next_count = count;
    next_tick  = 1'b0;
    if (clear) begin
      next_count = '0;
    end else if (stepIn) begin
      // Compare with >= so a smaller limit written mid-count wraps at once
      if (count >= limit) begin
        next_count = '0;
        next_tick  = 1'b1;
      end else begin
        next_count = count + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      count <= '0;
      tick  <= 1'b0;
    end else if (clkEn) begin
      count <= next_count;
      tick  <= next_tick;
    end
  end

  a_div_by_one : assert property (@(posedge core_clk iff clkEn) disable iff (!rst_b)
    (stepIn && !clear && limit == '0) |=> tick)
    else $error("divide by one did not tick on every step");

endmodule
`default_nettype wire

// file: core/system_mode_clock_config.sv
/*
  System mode and clock configuration: fuse capture, reset sequencing with
  selectable pin polarity, clock and timer dividers, software configuration
  registers and the fetch and execution pacing of compatibility or fast mode.
  Assumes fuses, the reset pin, the polarity pin and the power-on and
  brown-out detector levels are asynchronous; all other inputs are on core_clk.
*/
`default_nettype none
module system_mode_clock_config (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  input  wire logic       clkEn,
  // Reset sources, asynchronous
  input  wire logic       resetPin,
  input  wire logic       resetPolarityPin,
  input  wire logic       powerOnActive,
  input  wire logic       brownoutActive,
  // Fuses, asynchronous
  input  wire logic [1:0] fuseClockSource,
  input  wire logic [1:0] fuseStartup,
  input  wire logic       fuseCompatMode,
  input  wire logic       fuseIspEnable,
  input  wire logic       fuseSigProgEnable,
  input  wire logic       fuseTristate,
  input  wire logic       fuseSelfProgEnable,
  // Software register writes
  input  wire logic       sfrWrEn,
  input  wire logic [1:0] sfrWrSel,
  input  wire logic [7:0] sfrWrData,
  // CPU pacing
  input  wire logic       execStart,
  input  wire logic [1:0] execLen,
  input  wire logic       powerDownWake,
  // Configuration registers
  output var  logic [7:0] clockSetupRegister,
  output var  logic [7:0] auxiliaryRegister,
  output var  logic [7:0] memoryControlRegister,
  output var  logic [7:0] portModeRegister,
  // Captured fuse settings and gated permissions
  output var  logic       fastMode,
  output var  logic [1:0] clockSource,
  output var  logic       ispAllowed,
  output var  logic       sigProgAllowed,
  output var  logic       selfProgAllowed,
  // Reset and clock status
  output var  logic       deviceReset,
  output var  logic       clockReady,
  // Timing strobes
  output var  logic       sysTick,
  output var  logic       timerTick,
  output var  logic       fetchStrobe,
  output var  logic       execBusy,
  output var  logic       execDone
);

  localparam int ASYNC_W     = 13;
  localparam int STARTUP_MAX = system_mode_clock_pkg::STARTUP3_CYC + 2;

  typedef enum logic [1:0] {S_RESET, S_STARTUP, S_WAKE, S_RUN} seq_state_e;

  function automatic logic [9:0] startupCycles(input logic [1:0] sel);
    unique case (sel)
      2'h0: startupCycles = 10'(system_mode_clock_pkg::STARTUP0_CYC);
      2'h1: startupCycles = 10'(system_mode_clock_pkg::STARTUP1_CYC);
      2'h2: startupCycles = 10'(system_mode_clock_pkg::STARTUP2_CYC);
      2'h3: startupCycles = 10'(system_mode_clock_pkg::STARTUP3_CYC);
    endcase
  endfunction

  // Two-stage synchroniser for every asynchronous input
  logic [ASYNC_W-1:0] asyncIn;
  logic [ASYNC_W-1:0] syncMeta;
  logic [ASYNC_W-1:0] syncOut;

  assign asyncIn = {resetPin, resetPolarityPin, powerOnActive, brownoutActive,
                    fuseClockSource, fuseStartup, fuseCompatMode, fuseIspEnable,
                    fuseSigProgEnable, fuseTristate, fuseSelfProgEnable};

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      syncMeta <= '0;
      syncOut  <= '0;
    end else if (clkEn) begin
      syncMeta <= asyncIn;
      syncOut  <= syncMeta;
    end
  end

  logic       sPin;
  logic       sPolarity;
  logic       sPowerOn;
  logic       sBrownout;
  logic [1:0] sClockSource;
  logic [1:0] sStartup;
  logic       sCompat;
  logic       sIsp;
  logic       sSigProg;
  logic       sTristate;
  logic       sSelfProg;

  assign {sPin, sPolarity, sPowerOn, sBrownout, sClockSource, sStartup, sCompat,
          sIsp, sSigProg, sTristate, sSelfProg} = syncOut;

  // Reset sequencing and fuse capture
  seq_state_e state;
  seq_state_e next_state;
  logic [9:0] startCnt;
  logic [9:0] next_startCnt;
  logic [3:0] extCnt;
  logic [3:0] next_extCnt;
  logic [1:0] settleCnt;
  logic [1:0] next_settleCnt;
  logic [1:0] startupSel;
  logic [1:0] next_startupSel;
  logic       polarityLatch;
  logic       next_polarityLatch;
  logic       next_fastMode;
  logic [1:0] next_clockSource;
  logic       next_ispAllowed;
  logic       next_sigProgAllowed;
  logic       fuseSelfProgLatch;
  logic       next_fuseSelfProgLatch;
  logic       tristateLatch;
  logic       next_tristateLatch;
  logic       next_deviceReset;
  logic       next_clockReady;
  logic       extAsserted;
  logic       extQualified;
  logic [3:0] extMin;
  logic       resetReq;

  // Pull resistors on the pin are analog; only the active level lives here
  assign extAsserted  = polarityLatch ? sPin : !sPin;
  // Pulses shorter than the least width are ignored
  assign extMin       = fastMode ? 4'(system_mode_clock_pkg::RST_MIN_FAST)
                                 : 4'(system_mode_clock_pkg::RST_MIN_COMPAT);
  assign extQualified = (extCnt >= extMin);
  assign resetReq     = sPowerOn || sBrownout || extQualified;

  always_comb begin
    next_state             = state;
    next_startCnt          = startCnt;
    next_extCnt            = extCnt;
    next_startupSel        = startupSel;
    next_polarityLatch     = polarityLatch;
    next_fastMode          = fastMode;
    next_clockSource       = clockSource;
    next_ispAllowed        = ispAllowed;
    next_sigProgAllowed    = sigProgAllowed;
    next_fuseSelfProgLatch = fuseSelfProgLatch;
    next_tristateLatch     = tristateLatch;
    next_settleCnt         = '0;
    if (!extAsserted) begin
      next_extCnt = '0;
    end else if (sysTick && !extQualified) begin
      next_extCnt = extCnt + 4'h1;
    end
    unique case (state)
      S_RESET: begin
        // Capture only while reset is held, so nothing shifts mid-run
        next_polarityLatch     = sPolarity;
        next_startupSel        = sStartup;
        next_fastMode          = !sCompat;
        next_clockSource       = sClockSource;
        next_ispAllowed        = sIsp;
        next_sigProgAllowed    = sSigProg;
        next_fuseSelfProgLatch = sSelfProg;
        next_tristateLatch     = sTristate;
        // Synchroniser depth: before that the fuse levels are still reset zeros
        next_settleCnt = (settleCnt == 2'h2) ? settleCnt : settleCnt + 2'h1;
        if (!resetReq && settleCnt == 2'h2) begin
          next_state    = S_STARTUP;
          next_startCnt = startupCycles(sStartup);
        end
      end
      S_STARTUP, S_WAKE: begin
        if (resetReq) begin
          next_state = S_RESET;
        end else if (startCnt <= 10'h001) begin
          next_state    = S_RUN;
          next_startCnt = '0;
        end else begin
          next_startCnt = startCnt - 10'h001;
        end
      end
      S_RUN: begin
        if (resetReq) begin
          next_state = S_RESET;
        end else if (powerDownWake) begin
          next_state    = S_WAKE;
          next_startCnt = startupCycles(startupSel);
        end
      end
    endcase
    next_deviceReset = (next_state == S_RESET) || (next_state == S_STARTUP);
    next_clockReady  = (next_state == S_RUN);
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state             <= S_RESET;
      startCnt          <= '0;
      extCnt            <= '0;
      settleCnt         <= '0;
      startupSel        <= 2'h0;
      polarityLatch     <= 1'b0;
      fastMode          <= 1'b0;
      clockSource       <= 2'h0;
      ispAllowed        <= 1'b0;
      sigProgAllowed    <= 1'b0;
      fuseSelfProgLatch <= 1'b0;
      tristateLatch     <= 1'b0;
      deviceReset       <= 1'b1;
      clockReady        <= 1'b0;
    end else if (clkEn) begin
      state             <= next_state;
      startCnt          <= next_startCnt;
      extCnt            <= next_extCnt;
      settleCnt         <= next_settleCnt;
      startupSel        <= next_startupSel;
      polarityLatch     <= next_polarityLatch;
      fastMode          <= next_fastMode;
      clockSource       <= next_clockSource;
      ispAllowed        <= next_ispAllowed;
      sigProgAllowed    <= next_sigProgAllowed;
      fuseSelfProgLatch <= next_fuseSelfProgLatch;
      tristateLatch     <= next_tristateLatch;
      deviceReset       <= next_deviceReset;
      clockReady        <= next_clockReady;
    end
  end

  // Software configuration registers
  logic [7:0] next_clockSetup;
  logic [7:0] next_aux;
  logic [7:0] next_memCtl;
  logic [7:0] next_portMode;
  logic       next_selfProgAllowed;

  always_comb begin
    next_clockSetup = clockSetupRegister;
    next_aux        = auxiliaryRegister;
    next_memCtl     = memoryControlRegister;
    next_portMode   = portModeRegister;
    if (state == S_RESET) begin
      // Defaults follow the fuses being captured in the same cycle
      next_clockSetup = sCompat ? system_mode_clock_pkg::CLK_RESET_COMPAT
                                : system_mode_clock_pkg::CLK_RESET_FAST;
      next_aux        = system_mode_clock_pkg::AUX_RESET;
      next_memCtl     = system_mode_clock_pkg::MEM_RESET;
      next_portMode   = sTristate ? system_mode_clock_pkg::PORT_MODE_REGISTER_RESET_INPUT
                                  : system_mode_clock_pkg::PORT_MODE_REGISTER_RESET_QUASI;
    end else if (sfrWrEn && state == S_RUN) begin
      unique case (sfrWrSel)
        // Bit 0 of the clock register is not implemented
        system_mode_clock_pkg::SEL_CLOCK: next_clockSetup = {sfrWrData[7:1], 1'b0};
        system_mode_clock_pkg::SEL_AUX:   next_aux        = {4'h0,
                                                             sfrWrData[3:0]};
        system_mode_clock_pkg::SEL_MEM:   next_memCtl     = {sfrWrData[7], 3'h0,
                                                             sfrWrData[3], 3'h0};
        system_mode_clock_pkg::SEL_PORT:  next_portMode   = sfrWrData;
      endcase
    end
    next_selfProgAllowed = fuseSelfProgLatch &&
                           next_memCtl[system_mode_clock_pkg::MEM_SELFPROG_BIT];
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      clockSetupRegister    <= system_mode_clock_pkg::CLK_RESET_COMPAT;
      auxiliaryRegister     <= system_mode_clock_pkg::AUX_RESET;
      memoryControlRegister <= system_mode_clock_pkg::MEM_RESET;
      portModeRegister      <= system_mode_clock_pkg::PORT_MODE_REGISTER_RESET_QUASI;
      selfProgAllowed       <= 1'b0;
    end else if (clkEn) begin
      clockSetupRegister    <= next_clockSetup;
      auxiliaryRegister     <= next_aux;
      memoryControlRegister <= next_memCtl;
      portModeRegister      <= next_portMode;
      selfProgAllowed       <= next_selfProgAllowed;
    end
  end

  // Oscillator to system clock, then system clock to timer base
  logic [2:0] clkDivSel;
  logic [3:0] timerScaleSel;
  logic [6:0] sysLimit;

  assign clkDivSel     = clockSetupRegister[system_mode_clock_pkg::CLK_DIV_LSB +: 3];
  assign timerScaleSel = clockSetupRegister[system_mode_clock_pkg::TMR_SCALE_LSB +: 4];
  // Power-of-two ratio, 1 up to 128
  assign sysLimit      = 7'((8'h01 << clkDivSel) - 8'h01);

  rate_divider #(
    .WIDTH (7)
  ) u_sys_div (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .clkEn    (clkEn),
    .clear    (state == S_RESET),
    .stepIn   (1'b1),
    .limit    (sysLimit),
    .tick     (sysTick)
  );

  // Linear ratio, field value plus one
  rate_divider #(
    .WIDTH (4)
  ) u_timer_div (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .clkEn    (clkEn),
    .clear    (state == S_RESET),
    .stepIn   (sysTick),
    .limit    (timerScaleSel),
    .tick     (timerTick)
  );

  // Fetch pacing and execution length
  logic [1:0] fetchPhase;
  logic [1:0] next_fetchPhase;
  logic [4:0] execCnt;
  logic [4:0] next_execCnt;
  logic       next_fetchStrobe;
  logic       next_execBusy;
  logic       next_execDone;
  logic       execTake;
  logic       running;

  assign running  = (state == S_RUN);
  assign execTake = execStart && running && (execCnt == '0);

  always_comb begin
    next_fetchPhase  = fetchPhase;
    next_fetchStrobe = 1'b0;
    next_execCnt     = execCnt;
    next_execDone    = 1'b0;
    if (!running) begin
      next_fetchPhase = '0;
      next_execCnt    = '0;
    end else begin
      if (sysTick) begin
        if (fastMode) begin
          next_fetchStrobe = 1'b1;
        end else if (fetchPhase == 2'(system_mode_clock_pkg::COMPAT_FETCH_TICKS - 1)) begin
          next_fetchPhase  = '0;
          next_fetchStrobe = 1'b1;
        end else begin
          next_fetchPhase = fetchPhase + 2'h1;
        end
      end
      if (execTake) begin
        // Compatibility stretches each cycle to a six-state machine cycle
        next_execCnt = fastMode ? 5'({3'h0, execLen} + 5'h01)
                                : 5'(({3'h0, execLen} + 5'h01) *
                                     5'(system_mode_clock_pkg::COMPAT_STATE_TICKS));
      end else if (sysTick && execCnt != '0) begin
        next_execCnt  = execCnt - 5'h01;
        next_execDone = (execCnt == 5'h01);
      end
    end
    next_execBusy = (next_execCnt != '0);
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      fetchPhase  <= '0;
      fetchStrobe <= 1'b0;
      execCnt     <= '0;
      execBusy    <= 1'b0;
      execDone    <= 1'b0;
    end else if (clkEn) begin
      fetchPhase  <= next_fetchPhase;
      fetchStrobe <= next_fetchStrobe;
      execCnt     <= next_execCnt;
      execBusy    <= next_execBusy;
      execDone    <= next_execDone;
    end
  end

  // Checks
  default clocking cb @(posedge core_clk iff clkEn); endclocking
  default disable iff (!rst_b);

  sequence s_leave_reset;
    $past(state) == S_RESET && state == S_STARTUP;
  endsequence

  sequence s_startup_done;
    ##[1:STARTUP_MAX] state != S_STARTUP;
  endsequence

  a_fast_fetch_rate : assert property (running && fastMode && sysTick |=> fetchStrobe)
    else $error("fast mode missed a fetch on a system tick");

  a_compat_fetch_gap : assert property (fetchStrobe && !fastMode |->
    $past(fetchPhase) == 2'h2 && $past(sysTick))
    else $error("compatibility fetch not on third tick");

  a_fast_exec_len : assert property (execTake && fastMode |=>
    execCnt >= 5'h01 && execCnt <= 5'h04)
    else $error("fast execution length outside one to four");

  a_compat_exec_len : assert property (execTake && !fastMode |=>
    execCnt == 5'(({3'h0, $past(execLen)} + 5'h01) * 5'h06))
    else $error("compatibility execution not six clocks per cycle");

  a_reset_clock_default : assert property (state == S_RESET |=>
    clockSetupRegister == (fastMode ? system_mode_clock_pkg::CLK_RESET_FAST
                                    : system_mode_clock_pkg::CLK_RESET_COMPAT))
    else $error("clock register default does not match mode fuse");

  a_port_default : assert property (state == S_RESET |=>
    portModeRegister == (tristateLatch ? system_mode_clock_pkg::PORT_MODE_REGISTER_RESET_INPUT
                                       : system_mode_clock_pkg::PORT_MODE_REGISTER_RESET_QUASI))
    else $error("port mode default does not match tristate fuse");

  a_fuse_held : assert property (state != S_RESET && $past(state) != S_RESET |->
    $stable(fastMode) && $stable(clockSource) && $stable(polarityLatch))
    else $error("captured fuse changed outside reset");

  a_selfprog_gate : assert property (selfProgAllowed |-> fuseSelfProgLatch &&
    memoryControlRegister[system_mode_clock_pkg::MEM_SELFPROG_BIT])
    else $error("self programming allowed without both enables");

  a_short_reset : assert property (state == S_RUN && !sPowerOn && !sBrownout &&
    extCnt < extMin |=> state != S_RESET)
    else $error("short external reset pulse was taken");

  a_startup_bound : assert property (s_leave_reset |-> s_startup_done)
    else $error("start-up delay did not finish in time");

  a_reset_output : assert property (resetReq && state == S_RUN |=> ##1 deviceReset)
    else $error("reset request did not assert device reset");

endmodule
`default_nettype wire

// file: bench/board_reset_source.sv
/* Board reset source: reset pin held at its pull level and a polarity strap.
   Assumes press is called just after a core_clk rising edge. */
`default_nettype none
module board_reset_source (
  // Clock
  input  wire logic core_clk,
  // Pins
  output var  logic resetPin,
  output var  logic resetPolarityPin
);
  timeunit 1ns;
  timeprecision 100ps;
  // Strapped low, so the pull-up keeps the idle pin high
  initial begin
    resetPolarityPin = 1'b0;
    resetPin = 1'b1;
  end
  // Whole core cycles only; short presses are commanded on purpose
  task automatic press(int cycles);
    resetPin = resetPolarityPin;
    repeat (cycles) @(posedge core_clk);
    #1 resetPin = ~resetPolarityPin;
  endtask
endmodule
`default_nettype wire

// file: bench/tb_system_mode_clock_config.sv
/* Bench for system_mode_clock_config: defaults per fuse set, writes, strobes, resets.
   Assumes the package and board_reset_source are compiled first. */
`default_nettype none
module tb_system_mode_clock_config;
  timeunit 1ns;
  timeprecision 100ps;
  logic       core_clk, rst_b, compat, tristate, selfFuse, isp, brownout, sfrWrEn;
  logic [1:0] src, sfrWrSel;
  logic [7:0] sfrWrData, clock_setup_register, auxReg, memReg, portReg;
  logic [1:0] clockSource;
  logic       fastMode, ispOk, sigOk, selfProg, devRst, ready, sysTick, timerTick, fetch;
  logic       execStart, powerOn, wake, execBusy, execDone;
  logic [1:0] execLen;
  wire logic  resetPin, resetPolarityPin;
  int         err_total = 0;
  int         num_checks = 0;
  int         g;
  typedef struct {logic c; logic t; logic [7:0] clk; logic [7:0] port; int fgap;} row_s;
  // Compat clock 0101/001/0 = 52, tristate ports all input-only = AA
  row_s rows [4] = '{'{1'b1, 1'b0, 8'h52, 8'h00, 6}, '{1'b1, 1'b1, 8'h52, 8'hAA, 6},
                     '{1'b0, 1'b0, 8'h00, 8'h00, 1}, '{1'b0, 1'b1, 8'h00, 8'hAA, 1}};

  board_reset_source u_board (.core_clk(core_clk), .resetPin(resetPin),
    .resetPolarityPin(resetPolarityPin));

  system_mode_clock_config u_dut (.core_clk(core_clk), .rst_b(rst_b), .clkEn(1'b1),
    .resetPin(resetPin), .resetPolarityPin(resetPolarityPin), .powerOnActive(powerOn),
    .brownoutActive(brownout), .fuseClockSource(src), .fuseStartup(src),
    .fuseCompatMode(compat), .fuseIspEnable(isp), .fuseSigProgEnable(~isp),
    .fuseTristate(tristate), .fuseSelfProgEnable(selfFuse), .sfrWrEn(sfrWrEn),
    .sfrWrSel(sfrWrSel), .sfrWrData(sfrWrData), .execStart(execStart), .execLen(execLen),
    .powerDownWake(wake), .clockSetupRegister(clock_setup_register), .auxiliaryRegister(auxReg),
    .memoryControlRegister(memReg), .portModeRegister(portReg), .fastMode(fastMode),
    .clockSource(clockSource), .ispAllowed(ispOk), .sigProgAllowed(sigOk),
    .selfProgAllowed(selfProg), .deviceReset(devRst), .clockReady(ready),
    .sysTick(sysTick), .timerTick(timerTick), .fetchStrobe(fetch), .execBusy(execBusy),
    .execDone(execDone));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic check(string name, logic [7:0] exp, logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic step(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // Start-up runs up to 800 cycles, so allow well beyond that
  task automatic wait_ready();
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 2000) begin
      step(1);
      n++;
    end
    check("clockReady", 8'h01, {7'h0, ready});
  endtask

  task automatic wr(logic [1:0] sel, logic [7:0] data);
    sfrWrEn = 1'b1;
    sfrWrSel = sel;
    sfrWrData = data;
    step(1);
    sfrWrEn = 1'b0;
    // Let one edge pass low so back-to-back writes stay separate pulses
    step(1);
  endtask

  function automatic logic strobe(int k);
    return k == 0 ? sysTick : (k == 1 ? fetch : timerTick);
  endfunction

  task automatic gap(int k, output int cyc);
    int n;
    n = 0;
    while (strobe(k) !== 1'b1 && n < 100) begin
      step(1);
      n++;
    end
    cyc = 0;
    do begin
      step(1);
      cyc++;
    end while (strobe(k) !== 1'b1 && cyc < 100);
  endtask

  initial begin
    rst_b = 1'b0;
    {compat, tristate, selfFuse, isp, brownout, sfrWrEn} = 6'h28;
    {execStart, execLen, powerOn, wake} = 5'h00;
    {src, sfrWrSel, sfrWrData} = 12'h000;
    step(4);
    foreach (rows[i]) begin
      {compat, tristate, isp, src} = {rows[i].c, rows[i].t, rows[i].t, 2'(i)};
      rst_b = 1'b0;
      step(4);
      rst_b = 1'b1;
      wait_ready();
      check("clockSetupRegister", rows[i].clk, clock_setup_register);
      check("portModeRegister", rows[i].port, portReg);
      check("fastMode", {7'h0, ~rows[i].c}, {7'h0, fastMode});
      check("fuses", {4'h0, src, isp, ~isp}, {4'h0, clockSource, ispOk, sigOk});
      gap(1, g);
      check("fetch gap", 8'(rows[i].fgap), 8'(g));
      $display("test defaults row %0d done", i);
    end
    wr(2'h1, 8'h0D);
    check("auxiliaryRegister", 8'h0D, auxReg);
    wr(2'h1, 8'hF2);
    check("auxiliaryRegister", 8'h02, auxReg);
    wr(2'h2, 8'hFF);
    check("memoryControlRegister", 8'h88, memReg);
    check("selfProgAllowed", 8'h01, {7'h0, selfProg});
    wr(2'h3, 8'h1B);
    check("portModeRegister", 8'h1B, portReg);
    wr(2'h0, 8'h32);
    check("clockSetupRegister", 8'h32, clock_setup_register);
    gap(0, g);
    check("sysTick gap", 8'h02, 8'(g));
    gap(2, g);
    check("timerTick gap", 8'h08, 8'(g));
    $display("test writes done");
    selfFuse = 1'b0;
    brownout = 1'b1;
    step(6);
    check("deviceReset", 8'h01, {7'h0, devRst});
    brownout = 1'b0;
    wait_ready();
    check("auxiliaryRegister", 8'h00, auxReg);
    wr(2'h2, 8'h80);
    check("selfProgAllowed", 8'h00, {7'h0, selfProg});
    $display("test brownout done");
    u_board.press(1);
    step(8);
    check("deviceReset short", 8'h00, {7'h0, devRst});
    u_board.press(8);
    step(2);
    check("deviceReset long", 8'h01, {7'h0, devRst});
    wait_ready();
    check("memoryControlRegister", 8'h00, memReg);
    $display("test pin reset done");
    // Fast mode, clock divide one: two-cycle instruction
    execLen = 2'h1;
    execStart = 1'b1;
    step(1);
    execStart = 1'b0;
    check("execBusy", 8'h01, {7'h0, execBusy});
    step(2);
    check("execDone fast", 8'h02, {6'h0, execDone, execBusy});
    $display("test fast execution done");
    compat = 1'b1;
    powerOn = 1'b1;
    step(6);
    check("deviceReset powerOn", 8'h01, {7'h0, devRst});
    powerOn = 1'b0;
    wait_ready();
    check("clockSetupRegister", 8'h52, clock_setup_register);
    gap(0, g);
    check("sysTick gap", 8'h02, 8'(g));
    // Started just after a system tick: six ticks of two core cycles each
    execLen = 2'h0;
    execStart = 1'b1;
    step(1);
    execStart = 1'b0;
    step(11);
    check("execDone compat", 8'h01, {6'h0, execDone, execBusy});
    step(1);
    check("execDone compat", 8'h02, {6'h0, execDone, execBusy});
    wake = 1'b1;
    step(1);
    wake = 1'b0;
    check("clockReady wake", 8'h00, {7'h0, ready});
    wait_ready();
    check("clockSetupRegister wake", 8'h52, clock_setup_register);
    $display("test power-on, compat execution and wake done");
    tally_and_finish();
  end

  initial begin
    #200us;
    err_total++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
